/* File: src/sock_irq_pkg.sv */
// Package with register map, bit fields and carriers of the socket block
package sock_irq_pkg;

  // Register byte addresses
  localparam logic [7:0] addr_socket2_command = 8'h02;
  localparam logic [7:0] addr_socket3_command = 8'h03;
  localparam logic [7:0] addr_socket0_event_status = 8'h04;
  localparam logic [7:0] addr_socket1_event_status = 8'h05;
  localparam logic [7:0] addr_socket2_event_status = 8'h06;
  localparam logic [7:0] addr_socket3_event_status = 8'h07;
  localparam logic [7:0] addr_interrupt_summary = 8'h08;
  localparam logic [7:0] addr_interrupt_enable_mask = 8'h09;

  // Command bit positions
  localparam int cmd_sys_setup = 0;
  localparam int cmd_open = 1;
  localparam int cmd_connect = 2;
  localparam int cmd_listen = 3;
  localparam int cmd_close = 4;
  localparam int cmd_send = 5;
  localparam int cmd_recv = 6;

  // Event status bit positions
  localparam int st_setup_done = 0;
  localparam int st_open_done = 1;
  localparam int st_established = 2;
  localparam int st_closed = 3;
  localparam int st_timeout = 4;
  localparam int st_send_done = 5;
  localparam int st_recv_done = 6;

  // Summary layout: event flags low nibble, receive flags high nibble
  localparam int sum_event_lsb = 0;
  localparam int sum_rx_lsb = 4;

  // Writable command bits; bits 0 and 7 are reserved
  localparam logic [7:0] cmd_valid_mask = 8'h7e;

  // Reset values
  localparam logic [7:0] command_reset = 8'h00;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] summary_reset = 8'h00;
  localparam logic [7:0] mask_reset = 8'h00;
  localparam logic [7:0] retry_count_reset = 8'h00;
  localparam logic [7:0] rdata_reset = 8'h00;

  // Host byte bus request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } host_req_s;

  // Per-channel report from the protocol engine, pulses except busy
  typedef struct packed {
    logic setup_done;
    logic open_done;
    logic established;
    logic close_done;
    logic send_done;
    logic recv_done;
    logic retransmit;
    logic busy;
    logic rx_data;
  } chan_event_s;

endpackage : sock_irq_pkg

/* File: src/chan_event_status.sv */
// One channel's read-clear event status register with retry timeout
`timescale 1ns/1ns
module chan_event_status
  import sock_irq_pkg::*;
#(
  parameter bit has_setup = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Engine events and retry limit
  input chan_event_s ev,
  input wire logic [7:0] retry_limit,
  // Host side
  input wire logic read_clear,
  output logic [7:0] status,
  output logic new_event,
  output logic timeout_hit
);

  logic [7:0] retry_count;
  logic [7:0] next_retry_count;
  logic [7:0] next_status;
  logic [7:0] set_bits;

  always_comb begin
    // Timeout once retransmissions pass the limit
    timeout_hit = ev.busy && ev.retransmit
      && (retry_count >= retry_limit);
    if (!ev.busy) begin
      next_retry_count = retry_count_reset;
    end else if (ev.retransmit && !timeout_hit) begin
      next_retry_count = retry_count + 8'h01;
    end else begin
      next_retry_count = retry_count;
    end
    set_bits = 8'h00;
    set_bits[st_setup_done] = has_setup && ev.setup_done;
    set_bits[st_open_done] = ev.open_done;
    set_bits[st_established] = ev.established;
    set_bits[st_closed] = ev.close_done;
    set_bits[st_timeout] = timeout_hit;
    set_bits[st_send_done] = ev.send_done;
    set_bits[st_recv_done] = ev.recv_done;
    // New events win over a read-clear in the same cycle
    next_status = (read_clear ? status_reset : status) | set_bits;
    new_event = |set_bits;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status <= status_reset;
      retry_count <= retry_count_reset;
    end else begin
      status <= next_status;
      retry_count <= next_retry_count;
    end
  end

  property p_timeout_sets;
    @(posedge clk) disable iff (rst)
    (ev.busy && ev.retransmit && retry_count >= retry_limit)
      |=> status[st_timeout];
  endproperty
  a_timeout_sets: assert property (p_timeout_sets)
    else $error("timeout bit not set after retry limit");

  property p_no_early_timeout;
    @(posedge clk) disable iff (rst)
    (!status[st_timeout] && ev.retransmit && retry_count < retry_limit)
      |=> !status[st_timeout];
  endproperty
  a_no_early_timeout: assert property (p_no_early_timeout)
    else $error("timeout raised before retry limit");

  property p_reserved_status;
    @(posedge clk) disable iff (rst)
    !status[7] && (has_setup || !status[st_setup_done]);
  endproperty
  a_reserved_status: assert property (p_reserved_status)
    else $error("reserved status bit set");

  property p_read_clears;
    @(posedge clk) disable iff (rst)
    (read_clear && !new_event) |=> (status == status_reset);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status not cleared by read");

endmodule : chan_event_status

/* File: src/socket_command_interrupt_regs.sv */
// Socket 2/3 command registers, event status and interrupt summary
`timescale 1ns/1ns
module socket_command_interrupt_regs
  import sock_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host byte bus
  input host_req_s host,
  output logic [7:0] host_rdata,
  // Protocol engine reports, channels 0 to 3
  input chan_event_s [3:0] chan_ev,
  input wire logic [7:0] retry_limit,
  input wire logic [7:0] sock2_protocol_option,
  input wire logic [7:0] sock3_protocol_option,
  // Commands to the protocol engine
  output logic [7:0] socket2_command,
  output logic [7:0] socket3_command,
  output logic [7:0] sock2_open_protocol,
  output logic [7:0] sock3_open_protocol,
  // Host interrupt
  output logic irq
);

  logic [7:0] chan_status [4];
  logic [3:0] chan_new_event;
  logic [3:0] chan_timeout;
  logic [3:0] read_clear;
  logic [7:0] interrupt_summary;
  logic [7:0] interrupt_enable_mask;
  logic [7:0] next_socket2_command;
  logic [7:0] next_socket3_command;
  logic [7:0] next_sock2_open_protocol;
  logic [7:0] next_sock3_open_protocol;
  logic [7:0] next_summary;
  logic [7:0] next_mask;
  logic [7:0] next_rdata;
  logic next_irq;
  logic [7:0] sum_set;
  logic [7:0] sum_clear;
  logic wr2;
  logic wr3;

  // Status register per channel; only channel 0 reports system setup
  for (genvar i = 0; i < 4; i++) begin : g_chan
    chan_event_status #(
      .has_setup(i == 0)
    ) u_status (
      .clk(clk),
      .rst(rst),
      .ev(chan_ev[i]),
      .retry_limit(retry_limit),
      .read_clear(read_clear[i]),
      .status(chan_status[i]),
      .new_event(chan_new_event[i]),
      .timeout_hit(chan_timeout[i])
    );
  end

  // Engine finish pulses that release each command bit
  function automatic logic [7:0] done_mask(input chan_event_s ev,
                                           input logic tmo);
    logic [7:0] m;
    m = 8'h00;
    m[cmd_open] = ev.open_done;
    m[cmd_connect] = ev.established || tmo;
    m[cmd_listen] = ev.established || tmo;
    m[cmd_close] = ev.close_done;
    m[cmd_send] = ev.send_done || tmo;
    m[cmd_recv] = ev.recv_done;
    return m;
  endfunction : done_mask

  // Command registers
  always_comb begin
    wr2 = host.wr && (host.addr == addr_socket2_command);
    wr3 = host.wr && (host.addr == addr_socket3_command);
    // Finished commands drop out; a write in the same cycle wins
    next_socket2_command = socket2_command
      & ~done_mask(chan_ev[2], chan_timeout[2]);
    next_socket3_command = socket3_command
      & ~done_mask(chan_ev[3], chan_timeout[3]);
    // Connect, listen, close, send and receive go straight to the engine
    if (wr2) begin
      next_socket2_command = host.wdata & cmd_valid_mask;
    end
    if (wr3) begin
      next_socket3_command = host.wdata & cmd_valid_mask;
    end
    // Protocol is captured when open is issued so later option writes
    // cannot change a socket mid-open
    next_sock2_open_protocol = sock2_open_protocol;
    next_sock3_open_protocol = sock3_open_protocol;
    if (wr2 && host.wdata[cmd_open]) begin
      next_sock2_open_protocol = sock2_protocol_option;
    end
    if (wr3 && host.wdata[cmd_open]) begin
      next_sock3_open_protocol = sock3_protocol_option;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      socket2_command <= command_reset;
      socket3_command <= command_reset;
      sock2_open_protocol <= command_reset;
      sock3_open_protocol <= command_reset;
    end else begin
      socket2_command <= next_socket2_command;
      socket3_command <= next_socket3_command;
      sock2_open_protocol <= next_sock2_open_protocol;
      sock3_open_protocol <= next_sock3_open_protocol;
    end
  end

  // Summary, mask and interrupt
  always_comb begin
    sum_set = 8'h00;
    for (int i = 0; i < 4; i++) begin
      sum_set[sum_event_lsb + i] = chan_new_event[i];
      sum_set[sum_rx_lsb + i] = chan_ev[i].rx_data;
    end
    sum_clear = 8'h00;
    if (host.wr && (host.addr == addr_interrupt_summary)) begin
      sum_clear = host.wdata;
    end
    // Set wins so an event landing on the clear is not lost
    next_summary = (interrupt_summary & ~sum_clear) | sum_set;
    next_mask = interrupt_enable_mask;
    if (host.wr && (host.addr == addr_interrupt_enable_mask)) begin
      next_mask = host.wdata;
    end
    // Taken from next values so the pin matches the registers exactly
    next_irq = |(next_summary & next_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_summary <= summary_reset;
      interrupt_enable_mask <= mask_reset;
      irq <= 1'b0;
    end else begin
      interrupt_summary <= next_summary;
      interrupt_enable_mask <= next_mask;
      irq <= next_irq;
    end
  end

  // Read port; the value read is the one before the clear
  always_comb begin
    read_clear = 4'h0;
    next_rdata = rdata_reset;
    if (!host.rd) begin
      next_rdata = host_rdata;
    end else if (host.addr == addr_socket2_command) begin
      next_rdata = socket2_command;
    end else if (host.addr == addr_socket3_command) begin
      next_rdata = socket3_command;
    end else if (host.addr == addr_socket0_event_status) begin
      next_rdata = chan_status[0];
      read_clear[0] = 1'b1;
    end else if (host.addr == addr_socket1_event_status) begin
      next_rdata = chan_status[1];
      read_clear[1] = 1'b1;
    end else if (host.addr == addr_socket2_event_status) begin
      next_rdata = chan_status[2];
      read_clear[2] = 1'b1;
    end else if (host.addr == addr_socket3_event_status) begin
      next_rdata = chan_status[3];
      read_clear[3] = 1'b1;
    end else if (host.addr == addr_interrupt_summary) begin
      next_rdata = interrupt_summary;
    end else if (host.addr == addr_interrupt_enable_mask) begin
      next_rdata = interrupt_enable_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      host_rdata <= rdata_reset;
    end else begin
      host_rdata <= next_rdata;
    end
  end

  property p_cmd_reserved;
    @(posedge clk) disable iff (rst)
    ((socket2_command | socket3_command) & ~cmd_valid_mask) == 8'h00;
  endproperty
  a_cmd_reserved: assert property (p_cmd_reserved)
    else $error("reserved command bit set");

  property p_cmd_self_clear;
    @(posedge clk) disable iff (rst)
    (socket2_command[cmd_open] && chan_ev[2].open_done && !wr2)
      |=> !socket2_command[cmd_open];
  endproperty
  a_cmd_self_clear: assert property (p_cmd_self_clear)
    else $error("open command did not clear on completion");

  property p_cmd_holds;
    @(posedge clk) disable iff (rst)
    (!wr3 && !chan_ev[3].recv_done) |=>
      (socket3_command[cmd_recv] == $past(socket3_command[cmd_recv]));
  endproperty
  a_cmd_holds: assert property (p_cmd_holds)
    else $error("receive command changed without cause");

  property p_open_protocol;
    @(posedge clk) disable iff (rst)
    (wr2 && host.wdata[cmd_open]) |=>
      (sock2_open_protocol == $past(sock2_protocol_option));
  endproperty
  a_open_protocol: assert property (p_open_protocol)
    else $error("open protocol not captured");

  property p_status_read;
    @(posedge clk) disable iff (rst)
    (host.rd && host.addr == addr_socket0_event_status)
      |=> (host_rdata == $past(chan_status[0]));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read returned wrong value");

  property p_event_flag;
    @(posedge clk) disable iff (rst)
    chan_new_event[1] |=> interrupt_summary[sum_event_lsb + 1];
  endproperty
  a_event_flag: assert property (p_event_flag)
    else $error("channel event flag not set");

  property p_rx_flag;
    @(posedge clk) disable iff (rst)
    chan_ev[3].rx_data |=> interrupt_summary[sum_rx_lsb + 3] ##1
      (interrupt_summary[sum_rx_lsb + 3] || $past(sum_clear[sum_rx_lsb + 3]));
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("receive flag not set or lost");

  property p_w1c;
    @(posedge clk) disable iff (rst)
    (host.wr && host.addr == addr_interrupt_summary && host.wdata[0]
      && !sum_set[0]) |=> !interrupt_summary[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear summary bit");

  property p_w0_keeps;
    @(posedge clk) disable iff (rst)
    (interrupt_summary[2] && !sum_clear[2]) |=> interrupt_summary[2];
  endproperty
  a_w0_keeps: assert property (p_w0_keeps)
    else $error("summary bit lost without a write of one");

  property p_mask_write;
    @(posedge clk) disable iff (rst)
    (host.wr && host.addr == addr_interrupt_enable_mask)
      |=> (interrupt_enable_mask == $past(host.wdata));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  property p_irq_level;
    @(posedge clk) disable iff (rst)
    irq == (|(interrupt_summary & interrupt_enable_mask));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt pin disagrees with summary and mask");

  property p_cmd_write;
    @(posedge clk) disable iff (rst)
    wr3 |=> (socket3_command == ($past(host.wdata) & cmd_valid_mask));
  endproperty
  a_cmd_write: assert property (p_cmd_write)
    else $error("command write not stored");

  // A stray load here would mean a phantom read that cleared status
  property p_rdata_holds;
    @(posedge clk) disable iff (rst)
    !host.rd |=> (host_rdata == $past(host_rdata));
  endproperty
  a_rdata_holds: assert property (p_rdata_holds)
    else $error("read data changed without a read");

endmodule : socket_command_interrupt_regs

/* File: bench/engine_model.sv */
// Protocol engine stand-in answering socket 2 and 3 commands
`timescale 1ns/1ns
module engine_model
  import sock_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands from the block
  input wire logic [7:0] socket2_command,
  input wire logic [7:0] socket3_command,
  // Bench control: answer delay, answer enable, forced events
  input wire logic [7:0] delay,
  input wire logic auto_en,
  input chan_event_s [3:0] inject,
  // Reports to the block
  output chan_event_s [3:0] chan_ev
);
  chan_event_s ans [2];
  logic [7:0] cnt [2];
  logic [7:0] cmd [2];
  assign cmd[0] = socket2_command;
  assign cmd[1] = socket3_command;
  // Count restarts at the answer, so a delay of 1 or more gives one answer
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      ans[i] <= '0;
      ans[i].busy <= |(cmd[i] & 8'h2c);
      if (rst || !auto_en || cmd[i] == 8'h00) begin
        cnt[i] <= 8'h00;
      end else if (cnt[i] == delay) begin
        cnt[i] <= 8'h00;
        if (cmd[i][1]) ans[i].open_done <= 1'b1;
        else if (cmd[i][2] || cmd[i][3]) ans[i].established <= 1'b1;
        else if (cmd[i][4]) ans[i].close_done <= 1'b1;
        else if (cmd[i][5]) ans[i].send_done <= 1'b1;
        else if (cmd[i][6]) ans[i].recv_done <= 1'b1;
      end else begin
        cnt[i] <= cnt[i] + 8'h01;
      end
    end
  end
  always_comb begin
    chan_ev = inject;
    chan_ev[2] = chan_event_s'(inject[2] | ans[0]);
    chan_ev[3] = chan_event_s'(inject[3] | ans[1]);
  end
endmodule : engine_model

/* File: bench/tb_top.sv */
// Self-checking bench for the socket command and interrupt registers
`timescale 1ns/1ns
module tb_top;
  import sock_irq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  host_req_s host = '0;
  logic [7:0] host_rdata, cmd2, cmd3, proto2, proto3;
  logic [7:0] retry_limit = 8'h00;
  logic [7:0] delay = 8'h02;
  logic [7:0] opt2 = 8'h00;
  logic [7:0] opt3 = 8'h00;
  logic irq;
  logic auto_en = 1'b0;
  chan_event_s [3:0] chan_ev;
  chan_event_s [3:0] inject = '0;
  chan_event_s e;
  int miscompares = 0;
  int n_checks = 0;

  always #2 clk = ~clk;

  socket_command_interrupt_regs dut_u (
    .clk(clk), .rst(rst), .host(host), .host_rdata(host_rdata),
    .chan_ev(chan_ev), .retry_limit(retry_limit),
    .sock2_protocol_option(opt2), .sock3_protocol_option(opt3),
    .socket2_command(cmd2), .socket3_command(cmd3),
    .sock2_open_protocol(proto2), .sock3_open_protocol(proto3), .irq(irq)
  );

  engine_model eng_u (
    .clk(clk), .rst(rst), .socket2_command(cmd2), .socket3_command(cmd3),
    .delay(delay), .auto_en(auto_en), .inject(inject), .chan_ev(chan_ev)
  );

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Strobes last one cycle, so a call never meets the previous release
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    host.addr = a;
    host.wdata = d;
    host.wr = 1'b1;
    @(negedge clk);
    host.wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    host.addr = a;
    host.rd = 1'b1;
    @(negedge clk);
    host.rd = 1'b0;
    check(host_rdata, exp);
  endtask : rd_chk

  task automatic pulse(input int ch, input chan_event_s v);
    @(negedge clk);
    inject[ch] = v;
    @(negedge clk);
    inject[ch] = '0;
  endtask : pulse

  task automatic run_cmd(input int c, input int b);
    logic [7:0] exp;
    int n;
    exp = (b == 3) ? 8'h04 : (b == 4) ? 8'h08 : 8'h01 << b;
    delay = (c == 3) ? 8'h1e : 8'h02;
    opt2 = 8'(8'h10 + b);
    opt3 = 8'(8'h30 + b);
    wr(8'(c), 8'h01 << b);
    n = 0;
    while ((c == 2 ? cmd2 : cmd3) !== 8'h00 && n < 60) begin
      @(negedge clk);
      n++;
    end
    check(c == 2 ? cmd2 : cmd3, 8'h00);
    if (b == 1) begin
      check(c == 2 ? proto2 : proto3, c == 2 ? opt2 : opt3);
    end
    rd_chk(addr_interrupt_summary, 8'h01 << c);
    rd_chk(8'(c + 4), exp);
    rd_chk(8'(c + 4), 8'h00);
    wr(addr_interrupt_summary, 8'h01 << c);
    rd_chk(addr_interrupt_summary, 8'h00);
  endtask : run_cmd

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    // Reset values, then one unmapped address
    for (int a = 2; a <= 10; a++) rd_chk(8'(a), 8'h00);
    check({7'h00, irq}, 8'h00);
    wr(addr_socket2_command, 8'hff);
    check(cmd2, 8'h7e);
    rd_chk(addr_socket2_command, 8'h7e);
    wr(addr_socket3_command, 8'h81);
    rd_chk(addr_socket3_command, 8'h00);
    wr(addr_socket2_command, 8'h00);
    wr(addr_socket2_event_status, 8'hff);
    rd_chk(addr_socket2_event_status, 8'h00);
    // Every command on both channels; channel 3 answers slowly
    auto_en = 1'b1;
    for (int c = 2; c <= 3; c++) begin
      for (int b = 1; b <= 6; b++) begin
        run_cmd(c, b);
      end
    end
    e = '0;
    e.setup_done = 1'b1;
    pulse(0, e);
    rd_chk(addr_socket0_event_status, 8'h01);
    pulse(1, e);
    rd_chk(addr_socket1_event_status, 8'h00);
    e = '0;
    e.open_done = 1'b1;
    pulse(1, e);
    rd_chk(addr_socket1_event_status, 8'h02);
    wr(addr_interrupt_summary, 8'hff);
    e = '0;
    e.rx_data = 1'b1;
    for (int c = 0; c <= 3; c++) begin
      pulse(c, e);
      rd_chk(addr_interrupt_summary, 8'h10 << c);
      wr(addr_interrupt_summary, 8'h10 << c);
    end
    // Masking: irq follows summary and mask with no extra cycle
    pulse(2, e);
    wr(addr_interrupt_enable_mask, 8'hbf);
    @(negedge clk);
    check({7'h00, irq}, 8'h00);
    rd_chk(addr_interrupt_enable_mask, 8'hbf);
    wr(addr_interrupt_enable_mask, 8'h40);
    @(negedge clk);
    check({7'h00, irq}, 8'h01);
    wr(addr_interrupt_summary, 8'h00);
    @(negedge clk);
    check({7'h00, irq}, 8'h01);
    wr(addr_interrupt_summary, 8'h40);
    @(negedge clk);
    check({7'h00, irq}, 8'h00);
    // Timeout on the third retransmit with a limit of two
    auto_en = 1'b0;
    retry_limit = 8'h02;
    wr(addr_socket2_command, 8'h04);
    e = '0;
    e.retransmit = 1'b1;
    repeat (2) pulse(2, e);
    check(cmd2, 8'h04);
    pulse(2, e);
    check(cmd2, 8'h00);
    rd_chk(addr_interrupt_summary, 8'h04);
    rd_chk(addr_socket2_event_status, 8'h10);
    give_verdict();
  end
endmodule : tb_top
